// File: design/lsr_defines.svh
// Constants of the light sensor readout: offsets, fields, resets, counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef LSR_DEFINES_SVH
`define LSR_DEFINES_SVH
`define LSR_TARGET_ADDR 7'h44
`define LSR_REG_CMD 3'h0
`define LSR_REG_CTL 3'h1
`define LSR_REG_UPPER 3'h2
`define LSR_REG_LOWER 3'h3
`define LSR_REG_RES_LO 3'h4
`define LSR_REG_RES_HI 3'h5
`define LSR_REG_CNT_LO 3'h6
`define LSR_REG_CNT_HI 3'h7
`define LSR_CMD_CORE_ON 7
`define LSR_CMD_PWR_DN 6
`define LSR_CMD_EXT_TIME 5
`define LSR_PTR_SYNC 7
`define LSR_PTR_CLR_INT 6
`define LSR_CTL_FLAG 5
`define LSR_CMD_RESET 8'h00
`define LSR_CTL_RESET 4'h0
`define LSR_UPPER_RESET 8'hff
`define LSR_LOWER_RESET 8'h00
`define LSR_DIODE_LIGHT 2'h2
`define LSR_CYC_W12 17'h01000
`define LSR_CYC_W8 17'h00100
`define LSR_CYC_W4 17'h00010
`define LSR_PERSIST_1 5'h01
`define LSR_PERSIST_4 5'h04
`define LSR_PERSIST_8 5'h08
`define LSR_PERSIST_16 5'h10
`endif

// File: design/lsr_pkg.sv
// Types shared by the light sensor readout modules.
// Assumes nothing beyond a SystemVerilog compiler.
package lsr_pkg;
  typedef enum logic [2:0] {
    LSR_IDLE, LSR_RX, LSR_ACK, LSR_TX, LSR_RACK
  } lsr_i2c_st_type;

  // Settings handed to the analog converter
  typedef struct packed {
    logic core_reset;
    logic power_down;
    logic [1:0] range_sel;
    logic [1:0] width_sel;
  } lsr_conv_cfg_type;

  // One register write from the serial port
  typedef struct packed {
    logic strobe;
    logic [2:0] addr;
    logic [7:0] data;
  } lsr_wr_type;
endpackage

// File: design/lsr_sync2.sv
// Two-stage synchroniser for pin levels.
// Assumes inputs change independently of mclk.
`timescale 1ns/100ps
`default_nettype none
module lsr_sync2 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '1;
      sync_out <= '1;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: design/lsr_int_eval.sv
// Threshold window check with persistence and a sticky interrupt flag.
// Assumes sample pulses once per finished integration, same clock.
`timescale 1ns/100ps
`default_nettype none
`include "lsr_defines.svh"
module lsr_int_eval (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sample,
  input wire logic [15:0] result,
  input wire logic [7:0] upper_limit_byte,
  input wire logic [7:0] lower_limit_byte,
  input wire logic [1:0] persist_sel,
  input wire logic clear,
  output logic flag
);
  logic [4:0] run_r;
  logic [4:0] run_nxt;
  logic [4:0] need;
  logic outside;
  logic hit;

  // Thresholds are the upper byte of a 16-bit limit
  assign outside = ($signed(result) > $signed({upper_limit_byte, 8'h00}))
                || ($signed(result) < $signed({lower_limit_byte, 8'h00}));
  assign need = (persist_sel == 2'h0) ? `LSR_PERSIST_1 :
                (persist_sel == 2'h1) ? `LSR_PERSIST_4 :
                (persist_sel == 2'h2) ? `LSR_PERSIST_8 :
                `LSR_PERSIST_16;
  // Saturate at need so a smaller persist setting cannot overrun it
  assign run_nxt = !outside ? 5'h00 :
                   (run_r >= need) ? need : run_r + 5'h01;
  assign hit = sample && outside && (run_nxt == need);

  // A clear restarts the run, so a new alarm needs the full persistence
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= 5'h00;
    end else if (clear) begin
      run_r <= 5'h00;
    end else if (sample) begin
      run_r <= run_nxt;
    end
  end

  // A new trigger in the clearing cycle wins over the clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else if (hit) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: design/lsr_light_readout.sv
// Light sensor readout: serial target port, register set, integration
// timing and the threshold interrupt.
// Assumes a host that clocks SCL far slower than mclk (at least 5
// mclk cycles per SCL phase) and a converter on mclk that presents its
// signed count whenever integ_end pulses.
`timescale 1ns/100ps
`default_nettype none
`include "lsr_defines.svh"
module lsr_light_readout #(
  parameter int CYC_W16 = 65536
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_n_out,
  output logic int_n_oe,
  input wire logic [14:0] conv_count,
  output var lsr_pkg::lsr_conv_cfg_type conv_cfg,
  output logic integ_end
);
  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  lsr_sync2 #(.W(2)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

  // ------------------------------------------------------------
  // Register set
  // ------------------------------------------------------------
  logic [7:0] cmd_r;
  logic [3:0] ctl_r;
  logic [7:0] upper_r;
  logic [7:0] lower_r;
  logic [15:0] result_r;
  logic [15:0] timer_r;
  logic int_flag;
  lsr_pkg::lsr_wr_type wr;

  function automatic logic [7:0] rd_mux(input logic [2:0] a,
      input logic [7:0] cmd, input logic [7:0] ctl,
      input logic [7:0] up, input logic [7:0] lo,
      input logic [15:0] res, input logic [15:0] tim);
    logic [7:0] v;
    v = 8'h00;
    if (a == `LSR_REG_CMD) begin
      v = cmd & 8'hef;
    end else if (a == `LSR_REG_CTL) begin
      v = ctl;
    end else if (a == `LSR_REG_UPPER) begin
      v = up;
    end else if (a == `LSR_REG_LOWER) begin
      v = lo;
    end else if (a == `LSR_REG_RES_LO) begin
      v = res[7:0];
    end else if (a == `LSR_REG_RES_HI) begin
      v = res[15:8];
    end else if (a == `LSR_REG_CNT_LO) begin
      v = tim[7:0];
    end else begin
      v = tim[15:8];
    end
    return v;
  endfunction

  wire logic [7:0] ctl_view = {2'h0, int_flag, 1'b0, ctl_r};

  // Writes to result and timer addresses are dropped
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_r <= `LSR_CMD_RESET;
      ctl_r <= `LSR_CTL_RESET;
      upper_r <= `LSR_UPPER_RESET;
      lower_r <= `LSR_LOWER_RESET;
    end else if (wr.strobe) begin
      if (wr.addr == `LSR_REG_CMD) begin
        cmd_r <= wr.data & 8'hef;
      end else if (wr.addr == `LSR_REG_CTL) begin
        ctl_r <= wr.data[3:0];
      end else if (wr.addr == `LSR_REG_UPPER) begin
        upper_r <= wr.data;
      end else if (wr.addr == `LSR_REG_LOWER) begin
        lower_r <= wr.data;
      end
    end
  end

  // ------------------------------------------------------------
  // Serial target port
  // ------------------------------------------------------------
  lsr_pkg::lsr_i2c_st_type st_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [1:0] phase_r;
  logic rw_r;
  logic [2:0] ptr_r;
  logic sync_cmd;
  logic clr_cmd;
  logic [7:0] rd_byte;

  assign rd_byte = rd_mux(ptr_r, cmd_r, ctl_view, upper_r, lower_r,
                          result_r, timer_r);
  assign sda_out = 1'b0;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= lsr_pkg::LSR_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      phase_r <= 2'h0;
      rw_r <= 1'b0;
      ptr_r <= 3'h0;
      sda_oe <= 1'b0;
      wr <= '0;
      sync_cmd <= 1'b0;
      clr_cmd <= 1'b0;
    end else begin
      wr.strobe <= 1'b0;
      sync_cmd <= 1'b0;
      clr_cmd <= 1'b0;
      if (start_det) begin
        st_r <= lsr_pkg::LSR_RX;
        bit_cnt_r <= 4'h0;
        phase_r <= 2'h0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        st_r <= lsr_pkg::LSR_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_r)
          lsr_pkg::LSR_RX: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              sh_r <= {sh_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (phase_r == 2'h0) begin
                if (sh_r[7:1] == `LSR_TARGET_ADDR) begin
                  rw_r <= sh_r[0];
                  phase_r <= sh_r[0] ? 2'h2 : 2'h1;
                  st_r <= lsr_pkg::LSR_ACK;
                  sda_oe <= 1'b1;
                end else begin
                  st_r <= lsr_pkg::LSR_IDLE;
                end
              end else if (phase_r == 2'h1) begin
                ptr_r <= sh_r[2:0];
                sync_cmd <= sh_r[`LSR_PTR_SYNC];
                clr_cmd <= sh_r[`LSR_PTR_CLR_INT];
                phase_r <= 2'h2;
                st_r <= lsr_pkg::LSR_ACK;
                sda_oe <= 1'b1;
              end else begin
                wr.strobe <= 1'b1;
                wr.addr <= ptr_r;
                wr.data <= sh_r;
                ptr_r <= ptr_r + 3'h1;
                st_r <= lsr_pkg::LSR_ACK;
                sda_oe <= 1'b1;
              end
            end
          end
          lsr_pkg::LSR_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                sh_r <= rd_byte;
                sda_oe <= !rd_byte[7];
                ptr_r <= ptr_r + 3'h1;
                bit_cnt_r <= 4'h1;
                st_r <= lsr_pkg::LSR_TX;
              end else begin
                sda_oe <= 1'b0;
                st_r <= lsr_pkg::LSR_RX;
              end
            end
          end
          lsr_pkg::LSR_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe <= 1'b0;
                st_r <= lsr_pkg::LSR_RACK;
              end else begin
                sh_r <= {sh_r[6:0], 1'b0};
                sda_oe <= !sh_r[6];
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          lsr_pkg::LSR_RACK: begin
            if (scl_rise && sda_s) begin
              st_r <= lsr_pkg::LSR_IDLE;
            end else if (scl_fall) begin
              sh_r <= rd_byte;
              sda_oe <= !rd_byte[7];
              ptr_r <= ptr_r + 3'h1;
              bit_cnt_r <= 4'h1;
              st_r <= lsr_pkg::LSR_TX;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Integration timing
  // ------------------------------------------------------------
  logic [15:0] cyc_r;
  logic [16:0] period;
  logic core_run;
  logic light_mode;
  logic int_end_cond;
  logic ext_time;

  function automatic logic [16:0] period_of(input logic [1:0] w);
    logic [16:0] p;
    p = 17'h00000;
    if (w == 2'h0) begin
      p = 17'(CYC_W16);
    end else if (w == 2'h1) begin
      p = `LSR_CYC_W12;
    end else if (w == 2'h2) begin
      p = `LSR_CYC_W8;
    end else begin
      p = `LSR_CYC_W4;
    end
    return p;
  endfunction

  assign period = period_of(cmd_r[1:0]);
  assign ext_time = cmd_r[`LSR_CMD_EXT_TIME];
  // Diode modes 00, 01 and 11 all hold the converter off; only 10 runs it
  assign light_mode = cmd_r[3:2] == `LSR_DIODE_LIGHT;
  assign core_run = cmd_r[`LSR_CMD_CORE_ON] && !cmd_r[`LSR_CMD_PWR_DN]
                 && light_mode;
  assign int_end_cond = ext_time ? sync_cmd :
                        ({1'b0, cyc_r} >= period - 17'h00001);

  // Counter wraps at 16 bits in host-timed mode, like the timer bytes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_r <= 16'h0000;
      integ_end <= 1'b0;
    end else begin
      integ_end <= core_run && int_end_cond;
      if (!core_run || int_end_cond) begin
        cyc_r <= 16'h0000;
      end else begin
        cyc_r <= cyc_r + 16'h0001;
      end
    end
  end

  // Converter count is valid in the cycle integ_end is high
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      result_r <= 16'h0000;
      timer_r <= 16'h0000;
    end else if (core_run && int_end_cond) begin
      timer_r <= cyc_r + 16'h0001;
    end else if (integ_end) begin
      result_r <= {conv_count[14], conv_count};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_cfg <= '{core_reset: 1'b1, power_down: 1'b0,
                    range_sel: 2'h0, width_sel: 2'h0};
    end else begin
      conv_cfg.core_reset <= !cmd_r[`LSR_CMD_CORE_ON] || !light_mode;
      conv_cfg.power_down <= cmd_r[`LSR_CMD_PWR_DN];
      conv_cfg.range_sel <= ctl_r[3:2];
      conv_cfg.width_sel <= cmd_r[1:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------
  logic int_clear;
  logic result_new_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      result_new_r <= 1'b0;
    end else begin
      result_new_r <= integ_end;
    end
  end

  assign int_clear = clr_cmd || (wr.strobe && wr.addr == `LSR_REG_CTL
                     && !wr.data[`LSR_CTL_FLAG]);

  lsr_int_eval u_int (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sample(result_new_r),
    .result(result_r),
    .upper_limit_byte(upper_r),
    .lower_limit_byte(lower_r),
    .persist_sel(ctl_r[1:0]),
    .clear(int_clear),
    .flag(int_flag)
  );

  // Pin only ever pulls low
  assign int_n_out = 1'b0;
  assign int_n_oe = int_flag;
endmodule
`default_nettype wire

// File: tb/lsr_light_readout_asserts.sv
// Concurrent checks on the ports of the light sensor readout.
// Assumes binding onto lsr_light_readout; mclk is the only clock.
`timescale 1ns/100ps
`default_nettype none
module lsr_chk #(
  parameter int CYC_W16 = 65536
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic int_n_out,
  input wire logic int_n_oe,
  input wire lsr_pkg::lsr_conv_cfg_type conv_cfg,
  input wire logic integ_end
);
  // ----
  // Helper and properties
  // ----
  // Cycles since SCL last moved: a flag clear needs live bus traffic
  logic [3:0] quiet_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet_r <= 4'h0;
    end else if ($changed(scl_in)) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hf) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_sda_drain: assert property (sda_out == 1'b0)
    else $error("sda value not low");
  chk_int_drain: assert property (int_n_out == 1'b0)
    else $error("interrupt value not low");
  chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved while scl high");
  chk_int_sticky: assert property (quiet_r == 4'hf |-> !$fell(int_n_oe))
    else $error("interrupt dropped without bus traffic");
  chk_int_cause: assert property ($rose(int_n_oe) |->
    $past(integ_end, 2) || $past(integ_end, 3) || $past(integ_end, 4) ||
    $past(integ_end, 5))
    else $error("interrupt rose without a finished integration");
  chk_end_pulse: assert property (integ_end |=> !integ_end [*8])
    else $error("integration end too soon after the last");
  chk_pd_quiet: assert property (
    conv_cfg.power_down && $past(conv_cfg.power_down, 2) |-> !integ_end)
    else $error("integration ended in power-down");
  chk_core_quiet: assert property (
    conv_cfg.core_reset && $past(conv_cfg.core_reset, 2) |-> !integ_end)
    else $error("integration ended with core held");
  cover property (integ_end);
  cover property ($rose(int_n_oe));
  cover property ($rose(sda_oe));
endmodule
bind lsr_light_readout lsr_chk #(.CYC_W16(CYC_W16)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
  .conv_cfg(conv_cfg), .integ_end(integ_end));
`default_nettype wire

// File: tb/lsr_host.sv
// Bus host model: clocks SCL and pulls SDA low, one bit at a time.
// Assumes a 4 ns mclk; each SCL phase lasts at least six mclk periods.
`timescale 1ns/100ps
`default_nettype none
module lsr_host (
  input wire logic mclk,
  input wire logic sda,
  output var logic scl,
  output var logic sda_low
);
  // ----
  // Bus phases
  // ----
  // Host alone clocks the bus; SCL rests high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Wait out the target's SDA hold before a start or stop
  task automatic start();
    hp(6);
    sda_low = 1'b0;
    hp(3);
    scl = 1'b1;
    hp(3);
    sda_low = 1'b1;
    hp(3);
    scl = 1'b0;
  endtask
  task automatic stop();
    hp(6);
    sda_low = 1'b1;
    hp(3);
    scl = 1'b1;
    hp(3);
    sda_low = 1'b0;
    hp(6);
  endtask
  task automatic bitx(input logic tx, output logic rx);
    hp(3);
    sda_low = ~tx;
    hp(3);
    scl = 1'b1;
    hp(3);
    rx = sda;
    hp(3);
    scl = 1'b0;
  endtask
  // Ninth bit: last high releases SDA for acknowledge or ends a read
  task automatic xfer(input logic [7:0] tx, input logic last,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(last, ack);
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench: drives the readout through the host model.
// Assumes the bound checker and a 64-cycle integration at width 0 (CYC_W16).
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [14:0] conv_count = 15'h4321;
  logic scl, sda_low, sda_out, sda_oe, int_n_out, int_n_oe, integ_end;
  lsr_pkg::lsr_conv_cfg_type conv_cfg;
  int err_total = 0;
  int num_checks = 0;
  int pulses = 0;
  int at_int = 0;
  // Open drain with pull-up: low while either party pulls
  wire sda = ~(sda_low | sda_oe);
  logic [15:0] per [4] = '{16'h0040, 16'h1000, 16'h0100, 16'h0010};
  logic [15:0] pers [4] = '{16'h0001, 16'h0004, 16'h0008, 16'h0010};
  logic [7:0] rstv [8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00};
  logic [7:0] wv [5] = '{8'hff, 8'hff, 8'h5a, 8'h3c, 8'h55};
  logic [7:0] rv [5] = '{8'hef, 8'h0f, 8'h5a, 8'h3c, 8'h00};
  logic [7:0] quiet [5] = '{8'hcb, 8'h83, 8'h87, 8'h8f, 8'h0b};
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (integ_end === 1'b1) begin
      pulses++;
    end
  end
  always @(posedge int_n_oe) begin
    at_int = pulses;
  end
  lsr_light_readout #(.CYC_W16(64)) lsr_light_readout_inst (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_n_out(int_n_out),
    .int_n_oe(int_n_oe), .conv_count(conv_count), .conv_cfg(conv_cfg),
    .integ_end(integ_end));
  lsr_host lsr_host_inst (.mclk(mclk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d,
                    input logic has_d);
    logic [7:0] rx;
    logic [2:0] ak;
    lsr_host_inst.start();
    lsr_host_inst.xfer(8'h88, 1'b1, rx, ak[2]);
    lsr_host_inst.xfer(ptr, 1'b1, rx, ak[1]);
    ak[0] = 1'b0;
    if (has_d) begin
      lsr_host_inst.xfer(d, 1'b1, rx, ak[0]);
    end
    lsr_host_inst.stop();
    chk("wr_ack", 16'(ak), 16'h0000);
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] rx;
    logic [2:0] ak;
    logic nk;
    lsr_host_inst.start();
    lsr_host_inst.xfer(8'h88, 1'b1, rx, ak[2]);
    lsr_host_inst.xfer(ptr, 1'b1, rx, ak[1]);
    lsr_host_inst.start();
    lsr_host_inst.xfer(8'h89, 1'b1, rx, ak[0]);
    lsr_host_inst.xfer(8'hff, 1'b1, rx, nk);
    lsr_host_inst.stop();
    chk("rd_ack", 16'(ak), 16'h0000);
    chk($sformatf("reg%0h", ptr), 16'(rx), 16'(exp));
  endtask
  task automatic wait_end();
    int n;
    n = 0;
    @(posedge mclk);
    while (integ_end !== 1'b1 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 9000) begin
      err_total++;
      $display("BAD integ_end exp pulse seen none");
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    logic [7:0] rx;
    logic a;
    time t;
    int gap;
    int n;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i), rstv[i]);
    end
    lsr_host_inst.start();
    lsr_host_inst.xfer(8'h8a, 1'b1, rx, a);
    lsr_host_inst.stop();
    chk("foreign_addr_nack", 16'(a), 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wr(8'(i), wv[i], 1'b1);
      rd(8'(i), rv[i]);
    end
    foreach (quiet[i]) begin
      pulses = 0;
      wr(8'h00, quiet[i], 1'b1);
      repeat (100) @(negedge mclk);
      chk("quiet_ends", 16'(pulses), 16'h0000);
    end
    for (int w = 0; w < 4; w++) begin
      wr(8'h00, 8'h88 | 8'(w), 1'b1);
      wait_end();
      t = $time;
      wait_end();
      gap = int'(($time - t) / 4);
      chk("period", 16'(gap), per[w]);
      rd(8'h06, per[w][7:0]);
      rd(8'h07, per[w][15:8]);
      wr(8'h00, 8'h00, 1'b1);
    end
    rd(8'h04, 8'h21);
    rd(8'h05, 8'hc3);
    chk("conv_cfg", 16'(conv_cfg), 16'h002c);
    for (int p = 0; p < 4; p++) begin
      wr(8'h01, 8'(p), 1'b1);
      chk("flag_cleared", 16'(int_n_oe), 16'h0000);
      pulses = 0;
      wr(8'h00, 8'h8b, 1'b1);
      n = 0;
      while (int_n_oe !== 1'b1 && n < 3000) begin
        @(posedge mclk);
        n++;
      end
      chk("persist_fire", 16'(int_n_oe), 16'h0001);
      chk("persist_ends", 16'(at_int), pers[p]);
      wr(8'h00, 8'h00, 1'b1);
    end
    rd(8'h01, 8'h23);
    wr(8'h41, 8'h00, 1'b0);
    chk("ptr_clear", 16'(int_n_oe), 16'h0000);
    wr(8'h00, 8'hab, 1'b1);
    pulses = 0;
    t = $time;
    wr(8'h80, 8'h00, 1'b0);
    repeat (300) @(negedge mclk);
    gap = int'(($time - t) / 4);
    wr(8'h80, 8'h00, 1'b0);
    rd(8'h06, gap[7:0]);
    rd(8'h07, gap[15:8]);
    chk("sync_ends", 16'(pulses), 16'h0002);
    wrap_up();
  end
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
